// ### src/mmdec_top.sv
/*
 Memory map decoder for a Harvard core: program and data address decode,
 unified RAM in both spaces, peripheral and debug windows, vector fetch
 addresses and interrupt selection.
 Assumes core buses, variant strap and interrupt inputs are on clk_sys.
*/
//
// Behaviour
// - Vector n entry sits at vector base plus twice n words.
// - Vector jump targets are cut to nineteen address bits.
// - At reset vector base, vectors zero and one hit boot and watchdog entries.
// - RAM seen from data word zero and program word 0x8000, same storage.
// - All program and data addresses are twenty-four-bit word addresses.
// - Large variant flash 0x0000-0x1FFF, boot 0x0000, watchdog 0x0002.
// - Small variant flash 0x0800-0x1FFF, boot 0x0800, watchdog 0x0802, below reserved.
// - Data 0xF000-0xFFFF is peripherals; top 256 words are the debug window.
// - Vector 45 low software interrupt has fixed level minus one.
// - Converter zero-crossing or limit error uses vector 42, levels 0 to 2.
// - Debug status at 0xFFFFFD, transmit/receive data in the two words above.
// - First breakpoint address register, 24 bits, at 0xFFFF94 and 0xFFFF95.
// - Highest level first; lowest vector number wins within a level.
`include "mmdec_consts.svh"

module mmdec_top
   import mmdec_pkg::*;
(
   input  wire logic                             clk_sys,
   input  wire logic                             reset,
   input  wire logic                             clk_en,
   input  wire logic                             variant_small,
   input  wire logic                             vector_base_wr,
   input  wire mmdec_addr_t                      vector_base_wdata,
   input  wire logic                             prog_req,
   input  wire mmdec_addr_t                      prog_addr,
   input  wire logic                             data_req,
   input  wire mmdec_addr_t                      data_addr,
   input  wire logic                             data_byte,
   input  wire logic                             vec_req,
   input  wire mmdec_vec_t                       vec_num,
   input  wire logic [`MMDEC_NUM_VEC-1:0]        irq_pend,
   input  wire logic [2*`MMDEC_NUM_VEC-1:0]      irq_level,
   output mmdec_addr_t                           vector_base,
   output mmdec_addr_t                           boot_addr,
   output mmdec_addr_t                           wdog_addr,
   output logic                                  prog_valid,
   output mmdec_target_t                         prog_target,
   output mmdec_addr_t                           prog_index,
   output logic                                  data_valid,
   output mmdec_target_t                         data_target,
   output mmdec_addr_t                           data_index,
   output logic                                  dbg_sel_status,
   output logic                                  dbg_sel_data_lo,
   output logic                                  dbg_sel_data_hi,
   output logic                                  dbg_sel_bkpt1_lo,
   output logic                                  dbg_sel_bkpt1_hi,
   output logic                                  vec_valid,
   output logic [`MMDEC_JUMP_BITS-1:0]           vec_addr,
   output logic                                  vec_is_boot,
   output logic                                  vec_is_wdog,
   output logic                                  irq_valid,
   output mmdec_vec_t                            irq_vec,
   output mmdec_lvl_t                            irq_lvl,
   output logic                                  irq_adc_zc
);

   // Registered state
   mmdec_addr_t                      vbase_q;
   mmdec_addr_t                      boot_q;
   mmdec_addr_t                      wdog_q;
   logic                             pvalid_q;
   mmdec_target_t                    ptgt_q;
   mmdec_addr_t                      pidx_q;
   logic                             dvalid_q;
   mmdec_target_t                    dtgt_q;
   mmdec_addr_t                      didx_q;
   logic [4:0]                       dbg_q;
   logic                             vvalid_q;
   logic [`MMDEC_JUMP_BITS-1:0]      vaddr_q;
   logic                             vboot_q;
   logic                             vwdog_q;
   logic                             ivalid_q;
   mmdec_vec_t                       ivec_q;
   mmdec_lvl_t                       ilvl_q;
   logic                             iadc_q;

   // In-range test used by both address spaces
   function automatic logic in_range(input mmdec_addr_t a, input mmdec_addr_t lo, input mmdec_addr_t hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   // Variant dependent map
   mmdec_addr_t flash_first;
   mmdec_addr_t ram_words;
   mmdec_addr_t ram_last;
   mmdec_addr_t pram_last;
   mmdec_addr_t wdog_entry;

   assign flash_first = variant_small ? `MMDEC_FLASH_FIRST_SML : `MMDEC_FLASH_FIRST_BIG;
   assign wdog_entry  = flash_first + `MMDEC_WDOG_OFFSET;
   assign ram_words   = variant_small ? `MMDEC_RAM_WORDS_SML : `MMDEC_RAM_WORDS_BIG;
   assign ram_last    = ram_words - 24'h000001;
   assign pram_last   = `MMDEC_PRAM_BASE + ram_last;

   // Program space decode; addresses count words, never bytes
   logic        p_flash;
   logic        p_ram;
   mmdec_target_t p_tgt_d;
   mmdec_addr_t p_idx_d;

   assign p_flash = in_range(prog_addr, flash_first, `MMDEC_FLASH_LAST);
   assign p_ram   = in_range(prog_addr, `MMDEC_PRAM_BASE, pram_last);
   // Anything else, including words below small-variant flash, selects nothing
   assign p_tgt_d = p_flash ? MMDEC_TGT_FLASH :
                    p_ram   ? MMDEC_TGT_RAM   : MMDEC_TGT_NONE;
   assign p_idx_d = p_flash ? prog_addr - flash_first :
                    p_ram   ? prog_addr - `MMDEC_PRAM_BASE : '0;

   // Data space decode
   logic        d_ram;
   logic        d_periph;
   logic        d_debug;
   mmdec_target_t d_tgt_d;
   mmdec_addr_t d_idx_d;
   logic [4:0]  d_dbg_d;

   assign d_ram    = in_range(data_addr, 24'h000000, ram_last);
   // Byte access to a peripheral is not decoded so no register is half written
   assign d_periph = in_range(data_addr, `MMDEC_PERIPH_FIRST, `MMDEC_PERIPH_LAST) && !data_byte;
   assign d_debug  = data_addr >= `MMDEC_DEBUG_FIRST;
   assign d_tgt_d  = d_ram    ? MMDEC_TGT_RAM    :
                     d_periph ? MMDEC_TGT_PERIPH :
                     d_debug  ? MMDEC_TGT_DEBUG  : MMDEC_TGT_NONE;
   assign d_idx_d  = d_ram    ? data_addr :
                     d_periph ? data_addr - `MMDEC_PERIPH_FIRST :
                     d_debug  ? data_addr - `MMDEC_DEBUG_FIRST : '0;
   // Debug register strobes: status, data low/high, breakpoint one low/high
   logic        d_status;
   logic        d_data_lo;
   logic        d_data_hi;
   logic        d_bkpt1_lo;
   logic        d_bkpt1_hi;

   assign d_status   = data_addr == `MMDEC_DBG_STATUS;
   assign d_data_lo  = data_addr == `MMDEC_DBG_DATA_LO;
   assign d_data_hi  = data_addr == `MMDEC_DBG_DATA_HI;
   assign d_bkpt1_lo = data_addr == `MMDEC_DBG_BKPT1_LO;
   assign d_bkpt1_hi = data_addr == `MMDEC_DBG_BKPT1_HI;

   // Packed low to high in the order of the select outputs
   assign d_dbg_d    = {d_bkpt1_hi, d_bkpt1_lo, d_data_hi, d_data_lo, d_status};

   // Vector fetch address
   mmdec_addr_t vec_full;
   logic [`MMDEC_JUMP_BITS-1:0] vec_cut;
   mmdec_addr_t vec_off;

   assign vec_off  = {{(`MMDEC_AW-`MMDEC_VEC_BITS-1){1'b0}}, vec_num, 1'b0};
   assign vec_full = vbase_q + vec_off;
   assign vec_cut  = vec_full[`MMDEC_JUMP_BITS-1:0];

   // Interrupt selection
   logic        pick_valid;
   mmdec_vec_t  pick_vec;
   mmdec_lvl_t  pick_lvl;

   mmdec_irq_pick mmdec_irq_pick_inst (
      .irq_pend   (irq_pend),
      .irq_level  (irq_level),
      .pick_valid (pick_valid),
      .pick_vec   (pick_vec),
      .pick_lvl   (pick_lvl)
   );

   // Vector base resets onto the boot entry so vectors zero and one overlay it
   // A write lands on its edge; fetches sampled from the next edge use the new base
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         vbase_q <= flash_first;
      end else if (clk_en && vector_base_wr) begin
         vbase_q <= vector_base_wdata;
      end
   end

   // Boot and watchdog entries follow the variant strap
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         boot_q <= flash_first;
         wdog_q <= wdog_entry;
      end else if (clk_en) begin
         boot_q <= flash_first;
         wdog_q <= wdog_entry;
      end
   end

   // Program bus result
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pvalid_q <= 1'b0;
         ptgt_q   <= MMDEC_TGT_NONE;
         pidx_q   <= '0;
      end else if (clk_en) begin
         pvalid_q <= prog_req;
         ptgt_q   <= prog_req ? p_tgt_d : MMDEC_TGT_NONE;
         pidx_q   <= p_idx_d;
      end
   end

   // Data bus result
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dvalid_q <= 1'b0;
         dtgt_q   <= MMDEC_TGT_NONE;
         didx_q   <= '0;
      end else if (clk_en) begin
         dvalid_q <= data_req;
         dtgt_q   <= data_req ? d_tgt_d : MMDEC_TGT_NONE;
         // Index follows the address even on an idle cycle
         didx_q   <= d_idx_d;
      end
   end

   // Debug register selects, raised only for a requested data access
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dbg_q <= '0;
      end else if (clk_en) begin
         dbg_q <= data_req ? d_dbg_d : 5'h00;
      end
   end

   // Vector fetch result
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         vvalid_q <= 1'b0;
         vaddr_q  <= '0;
      end else if (clk_en) begin
         vvalid_q <= vec_req;
         // Only the low nineteen bits reach the jump target
         vaddr_q  <= vec_cut;
      end
   end

   // Overlay flags compare the full sum, so a cut address cannot alias an entry
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         vboot_q <= 1'b0;
         vwdog_q <= 1'b0;
      end else if (clk_en) begin
         vboot_q <= vec_req && (vec_full == boot_q);
         vwdog_q <= vec_req && (vec_full == wdog_q);
      end
   end

   // Interrupt selection result
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ivalid_q <= 1'b0;
         ivec_q   <= '0;
         ilvl_q   <= `MMDEC_LVL_NONE;
      end else if (clk_en) begin
         ivalid_q <= pick_valid;
         ivec_q   <= pick_vec;
         // Levels are biased by two; zero means nothing pending
         ilvl_q   <= pick_lvl;
      end
   end

   // Converter zero-crossing flag follows the winner
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         iadc_q <= 1'b0;
      end else if (clk_en) begin
         iadc_q <= pick_valid && (pick_vec == `MMDEC_VEC_ADC_ZC);
      end
   end

   assign vector_base      = vbase_q;
   assign boot_addr        = boot_q;
   assign wdog_addr        = wdog_q;
   assign prog_valid       = pvalid_q;
   assign prog_target      = ptgt_q;
   assign prog_index       = pidx_q;
   assign data_valid       = dvalid_q;
   assign data_target      = dtgt_q;
   assign data_index       = didx_q;
   assign dbg_sel_status   = dbg_q[0];
   assign dbg_sel_data_lo  = dbg_q[1];
   assign dbg_sel_data_hi  = dbg_q[2];
   assign dbg_sel_bkpt1_lo = dbg_q[3];
   assign dbg_sel_bkpt1_hi = dbg_q[4];
   assign vec_valid        = vvalid_q;
   assign vec_addr         = vaddr_q;
   assign vec_is_boot      = vboot_q;
   assign vec_is_wdog      = vwdog_q;
   assign irq_valid        = ivalid_q;
   assign irq_vec          = ivec_q;
   assign irq_lvl          = ilvl_q;
   assign irq_adc_zc       = iadc_q;

endmodule : mmdec_top

// ### src/mmdec_consts.svh
/*
 Memory map constants for the address decoder: region bounds, reset entries,
 debug window register words and interrupt vector numbers.
 Assumes inclusion by every decoder file; definitions only.
*/
`ifndef MMDEC_CONSTS_SVH
`define MMDEC_CONSTS_SVH

// Word address widths, vector number width and vector count
`define MMDEC_AW              24
`define MMDEC_JUMP_BITS       19
`define MMDEC_VEC_BITS        6
`define MMDEC_NUM_VEC         46
// Program space
`define MMDEC_FLASH_LAST      24'h001FFF
`define MMDEC_FLASH_FIRST_BIG 24'h000000
`define MMDEC_FLASH_FIRST_SML 24'h000800
`define MMDEC_WDOG_OFFSET     24'h000002
`define MMDEC_PRAM_BASE       24'h008000
// Unified RAM sizes in words
`define MMDEC_RAM_WORDS_BIG   24'h000800
`define MMDEC_RAM_WORDS_SML   24'h000400
// Data space
`define MMDEC_PERIPH_FIRST    24'h00F000
`define MMDEC_PERIPH_LAST     24'h00FFFF
`define MMDEC_DEBUG_FIRST     24'hFFFF00
`define MMDEC_DBG_STATUS      24'hFFFFFD
`define MMDEC_DBG_DATA_LO     24'hFFFFFE
`define MMDEC_DBG_DATA_HI     24'hFFFFFF
`define MMDEC_DBG_BKPT1_LO    24'hFFFF94
`define MMDEC_DBG_BKPT1_HI    24'hFFFF95
// Interrupt vectors and levels
`define MMDEC_VEC_FIRST_IRQ   6'h02
`define MMDEC_VEC_ADC_ZC      6'h2A
`define MMDEC_VEC_SOFT_LOW    6'h2D
`define MMDEC_LVL_NONE        3'h0
`define MMDEC_LVL_SOFT_LOW    3'h1
`define MMDEC_LVL_BIAS        3'h2

`endif

// ### src/mmdec_pkg.sv
/*
 Types shared by the memory map decoder and its interrupt priority picker.
 Assumes the constants header is included before use.
*/
`include "mmdec_consts.svh"

package mmdec_pkg;

   typedef logic [`MMDEC_AW-1:0]       mmdec_addr_t;
   typedef logic [`MMDEC_VEC_BITS-1:0] mmdec_vec_t;
   // Effective level biased by two: 0 none, 1 level -1, 2..5 levels 0..3
   typedef logic [2:0]                 mmdec_lvl_t;

   typedef enum logic [2:0] {
      MMDEC_TGT_NONE,
      MMDEC_TGT_FLASH,
      MMDEC_TGT_RAM,
      MMDEC_TGT_PERIPH,
      MMDEC_TGT_DEBUG
   } mmdec_target_t;

endpackage : mmdec_pkg

// ### src/mmdec_irq_pick.sv
/*
 Interrupt priority picker: maps each vector to its effective level and picks
 the highest level, lowest vector number among pending requests.
 Assumes pending and programmed levels are driven from the same clock domain.
*/
`include "mmdec_consts.svh"

module mmdec_irq_pick
   import mmdec_pkg::*;
(
   input  wire logic [`MMDEC_NUM_VEC-1:0]   irq_pend,
   input  wire logic [2*`MMDEC_NUM_VEC-1:0] irq_level,
   output logic                             pick_valid,
   output mmdec_vec_t                       pick_vec,
   output mmdec_lvl_t                       pick_lvl
);

   // Fixed, limited and reserved levels per vector
   function automatic mmdec_lvl_t eff_level(input int n, input logic [1:0] prog);
      mmdec_lvl_t l;
      l = mmdec_lvl_t'(prog) + `MMDEC_LVL_BIAS;
      if (n < 2 || n == 14 || n == 15 || n == 21 || n == 33 || n == 34)
         l = `MMDEC_LVL_NONE;
      else if (n <= 5)
         l = 3'h5;
      else if (n <= 10) begin
         if (prog == 2'h0)
            l = 3'h3;
      end else if (n == 11)
         l = 3'h4;
      else if (n == 12)
         l = 3'h3;
      else if (n == 13)
         l = 3'h2;
      else if (n == int'(`MMDEC_VEC_SOFT_LOW))
         l = `MMDEC_LVL_SOFT_LOW;
      else if (prog == 2'h3)
         l = 3'h4;
      return l;
   endfunction : eff_level

   always_comb begin
      mmdec_lvl_t lv;
      lv         = `MMDEC_LVL_NONE;
      pick_valid = 1'b0;
      pick_vec   = '0;
      pick_lvl   = `MMDEC_LVL_NONE;
      for (int n = 0; n < `MMDEC_NUM_VEC; n++) begin
         lv = eff_level(n, irq_level[2*n +: 2]);
         // Strictly greater keeps the lowest vector on a tie
         if (irq_pend[n] && lv > pick_lvl) begin
            pick_valid = 1'b1;
            pick_vec   = mmdec_vec_t'(n);
            pick_lvl   = lv;
         end
      end
   end

endmodule : mmdec_irq_pick

// ### testbench/mmdec_asserts.sv
/*
 Concurrent checks on the decoder top ports.
 Assumes a bind onto mmdec_top and a single clock domain.
*/
`include "mmdec_consts.svh"

module mmdec_asserts
   import mmdec_pkg::*;
(
   input wire logic                      clk_sys,
   input wire logic                      reset,
   input wire logic                      clk_en,
   input wire logic                      variant_small,
   input wire logic                      prog_req,
   input wire mmdec_addr_t               prog_addr,
   input wire logic                      data_req,
   input wire mmdec_addr_t               data_addr,
   input wire logic                      data_byte,
   input wire logic                      vec_req,
   input wire mmdec_vec_t                vec_num,
   input wire logic [`MMDEC_NUM_VEC-1:0] irq_pend,
   input wire mmdec_addr_t               vector_base,
   input wire mmdec_addr_t               boot_addr,
   input wire mmdec_target_t             prog_target,
   input wire mmdec_addr_t               prog_index,
   input wire mmdec_target_t             data_target,
   input wire mmdec_addr_t               data_index,
   input wire logic                      dbg_sel_status,
   input wire logic                      dbg_sel_bkpt1_lo,
   input wire logic                      dbg_sel_bkpt1_hi,
   input wire logic [18:0]               vec_addr,
   input wire logic                      vec_is_boot,
   input wire mmdec_vec_t                irq_vec,
   input wire mmdec_lvl_t                irq_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   sequence s_dreq(mmdec_addr_t lo, mmdec_addr_t hi);
      clk_en && data_req && !data_byte && data_addr >= lo && data_addr <= hi;
   endsequence
   sequence s_preq(mmdec_addr_t lo, mmdec_addr_t hi);
      clk_en && prog_req && prog_addr >= lo && prog_addr <= hi;
   endsequence
   a_status_select: assert property (
      s_dreq(24'hFFFFFD, 24'hFFFFFD) |=> dbg_sel_status && data_index == 24'h0000FD)
      else $error("status word not selected");
   a_bkpt_low_word: assert property (
      s_dreq(24'hFFFF94, 24'hFFFF94) |=> dbg_sel_bkpt1_lo && !dbg_sel_bkpt1_hi)
      else $error("breakpoint low word not selected");
   a_bkpt_high_word: assert property (
      s_dreq(24'hFFFF95, 24'hFFFF95) |=> dbg_sel_bkpt1_hi && !dbg_sel_bkpt1_lo)
      else $error("breakpoint high word not selected");
   a_periph_window: assert property (s_dreq(24'h00F000, 24'h00FFFF) |=>
      data_target == MMDEC_TGT_PERIPH && data_index == $past(data_addr) - 24'h00F000)
      else $error("peripheral window decode wrong");
   a_debug_window: assert property (s_dreq(24'hFFFF00, 24'hFFFFFF) |=> data_target == MMDEC_TGT_DEBUG)
      else $error("debug window decode wrong");
   a_periph_byte: assert property (
      clk_en && data_req && data_byte && data_addr inside {[24'h00F000:24'h00FFFF]} |=> data_target == MMDEC_TGT_NONE)
      else $error("byte access to peripherals selected");
   a_ram_alias: assert property (s_preq(24'h008000, 24'h0083FF) |=>
      prog_target == MMDEC_TGT_RAM && prog_index == $past(prog_addr) - 24'h008000)
      else $error("program view of RAM wrong");
   a_small_low: assert property (
      variant_small ##0 s_preq(24'h000000, 24'h0007FF) |=> prog_target == MMDEC_TGT_NONE)
      else $error("reserved low program words selected");
   a_vec_addr: assert property (
      clk_en && vec_req |=> vec_addr == 19'($past(vector_base) + {$past(vec_num), 1'b0}))
      else $error("vector entry address wrong");
   a_vec_overlay: assert property (
      clk_en && vec_req && vec_num == 6'h00 && vector_base == boot_addr |=> vec_is_boot)
      else $error("vector zero does not overlay boot");
   a_soft_low: assert property (clk_en && irq_pend == {1'b1, 45'h0} |=> irq_vec == 6'h2D && irq_lvl == 3'h1)
      else $error("low software interrupt level wrong");
endmodule : mmdec_asserts

bind mmdec_top mmdec_asserts mmdec_asserts_inst (.*);

// ### testbench/mmdec_core_bfm.sv
/*
 Behavioural processor core driving the program, data and vector buses.
 Assumes the bench calls cyc once for every cycle it wants driven.
*/
module mmdec_core_bfm
   import mmdec_pkg::*;
(
   input  wire logic  clk_sys,
   output logic       prog_req = 1'b0,
   output mmdec_addr_t prog_addr = '0,
   output logic       data_req = 1'b0,
   output mmdec_addr_t data_addr = '0,
   output logic       data_byte = 1'b0,
   output logic       vec_req = 1'b0,
   output mmdec_vec_t vec_num = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic cyc(input logic pr, input mmdec_addr_t pa, input logic dr, input mmdec_addr_t da,
                      input logic db, input logic vr, input mmdec_vec_t vn);
      @(posedge clk_sys);
      #1;
      prog_req = pr;
      prog_addr = pr ? pa : ~prog_addr; // Idle bus never repeats the last word
      data_req = dr;
      data_addr = dr ? da : ~data_addr;
      data_byte = db; // Byte only when the bench breaks word access on purpose
      vec_req = vr;
      vec_num = vr ? vn : ~vec_num;
   endtask : cyc
endmodule : mmdec_core_bfm

// ### testbench/mmdec_top_tb.sv
/*
 Self-checking bench for the memory map decoder.
 Assumes the core model drives the buses and the checker is bound in.
*/
`include "mmdec_consts.svh"

module mmdec_top_tb
   import mmdec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {mmdec_target_t t; mmdec_addr_t i; logic b; logic w; logic [4:0] s;} mmdec_note_t;
   logic clk_sys, reset, clk_en, variant_small, vector_base_wr, prog_req, data_req, data_byte, vec_req;
   mmdec_addr_t vector_base_wdata, prog_addr, data_addr, vector_base, boot_addr, wdog_addr, prog_index, data_index;
   mmdec_vec_t vec_num, irq_vec;
   logic [`MMDEC_NUM_VEC-1:0] irq_pend;
   logic [2*`MMDEC_NUM_VEC-1:0] irq_level;
   logic prog_valid, data_valid, vec_valid, vec_is_boot, vec_is_wdog, irq_valid, irq_adc_zc;
   logic dbg_sel_status, dbg_sel_data_lo, dbg_sel_data_hi, dbg_sel_bkpt1_lo, dbg_sel_bkpt1_hi;
   mmdec_target_t prog_target, data_target;
   logic [`MMDEC_JUMP_BITS-1:0] vec_addr;
   mmdec_lvl_t irq_lvl;
   mmdec_note_t pq[$], dq[$], vq[$];
   mmdec_addr_t base, fb;
   logic [31:0] rnd;
   int miscompares, check_count, cycles;
   mmdec_addr_t pa_list [16] = '{24'h000000, 24'h000001, 24'h000002, 24'h0007FF, 24'h000800, 24'h000802,
      24'h001FFF, 24'h002000, 24'h007FFF, 24'h008000, 24'h0083FF, 24'h008400, 24'h0087FF, 24'h008800, 24'hFFFFFF, 24'h000FFF};
   mmdec_addr_t da_list [16] = '{24'h000000, 24'h0003FF, 24'h000400, 24'h0007FF, 24'h000800, 24'h00F000,
      24'h00F000, 24'h00FFFF, 24'hFFFFFF, 24'h010000, 24'hFFFEFF, 24'hFFFF00, 24'hFFFF94, 24'hFFFF95, 24'hFFFFFD, 24'hFFFFFE};
   assign fb = variant_small ? 24'h000800 : 24'h000000;
   logic [4:0] dbg_sel;
   assign dbg_sel = {dbg_sel_status, dbg_sel_data_lo, dbg_sel_data_hi, dbg_sel_bkpt1_lo, dbg_sel_bkpt1_hi};
   mmdec_top mmdec_top_inst (.*);
   mmdec_core_bfm mmdec_core_bfm_inst (.*);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic acc(input mmdec_addr_t pa, input mmdec_addr_t da, input logic db);
      mmdec_note_t n;
      mmdec_addr_t rw;
      rw = variant_small ? 24'h000400 : 24'h000800;
      n = '{MMDEC_TGT_NONE, pa, 1'b0, 1'b0, 5'h00};
      if (pa >= fb && pa <= 24'h001FFF) n = '{MMDEC_TGT_FLASH, pa - fb, 1'b0, 1'b0, 5'h00};
      if (pa >= 24'h008000 && pa < 24'h008000 + rw) n = '{MMDEC_TGT_RAM, pa - 24'h008000, 1'b0, 1'b0, 5'h00};
      pq.push_back(n);
      n = '{MMDEC_TGT_NONE, da, 1'b0, 1'b0,
         {da == 24'hFFFFFD, da == 24'hFFFFFE, da == 24'hFFFFFF, da == 24'hFFFF94, da == 24'hFFFF95}};
      if (da < rw) n.t = MMDEC_TGT_RAM;
      if (da >= 24'h00F000 && da <= 24'h00FFFF && !db) n.t = MMDEC_TGT_PERIPH;
      if (n.t == MMDEC_TGT_PERIPH) n.i = da - 24'h00F000;
      if (da >= 24'hFFFF00) n.t = MMDEC_TGT_DEBUG;
      if (da >= 24'hFFFF00) n.i = da - 24'hFFFF00;
      dq.push_back(n);
      mmdec_core_bfm_inst.cyc(1'b1, pa, 1'b1, da, db, 1'b0, 6'h00);
   endtask : acc
   task automatic vec(input mmdec_vec_t v);
      mmdec_addr_t sum;
      sum = base + {v, 1'b0};
      vq.push_back('{MMDEC_TGT_NONE, {5'h00, sum[18:0]}, sum == fb, sum == fb + 24'h000002, 5'h00});
      mmdec_core_bfm_inst.cyc(1'b0, 24'h000000, 1'b0, 24'h000000, 1'b0, 1'b1, v);
   endtask : vec
   task automatic irq(input int va, input int ca, input int vb, input int cb,
                      input logic [5:0] ev, input logic [2:0] el);
      @(posedge clk_sys);
      #1;
      irq_pend = '0;
      irq_level = '0;
      irq_pend[va] = 1'b1;
      irq_pend[vb] = 1'b1;
      irq_level[2*va +: 2] = ca[1:0];
      irq_level[2*vb +: 2] = cb[1:0];
      repeat (2) @(posedge clk_sys);
      #1;
      chk("irq_valid", irq_valid, 1'b1);
      chk("irq_vec", irq_vec, ev);
      chk("irq_lvl", irq_lvl, el);
      chk("irq_adc_zc", irq_adc_zc, ev == 6'h2A);
   endtask : irq

   always @(negedge clk_sys) begin
      mmdec_note_t n;
      if (prog_valid === 1'b1) begin
         n = pq.pop_front();
         chk("prog_target", prog_target, n.t);
         if (n.t != MMDEC_TGT_NONE) chk("prog_index", prog_index, n.i);
      end
      if (data_valid === 1'b1) begin
         n = dq.pop_front();
         chk("data_target", data_target, n.t);
         if (n.t != MMDEC_TGT_NONE) chk("data_index", data_index, n.i);
         chk("dbg_sel", dbg_sel, n.s);
      end
      if (vec_valid === 1'b1) begin
         n = vq.pop_front();
         chk("vec_addr", vec_addr, n.i);
         chk("vec_overlay", {vec_is_boot, vec_is_wdog}, {n.b, n.w});
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      {reset, clk_en, variant_small, vector_base_wr, vector_base_wdata, irq_pend, irq_level} = '0;
      reset = 1'b1;
      clk_en = 1'b1;
      rnd = 32'h6E92;
      for (int sm = 0; sm < 2; sm++) begin
         @(posedge clk_sys);
         #1;
         reset = 1'b1;
         variant_small = sm[0];
         repeat (5) @(posedge clk_sys);
         #1;
         reset = 1'b0;
         base = fb;
         chk("vector_base", vector_base, fb);
         chk("boot_addr", boot_addr, fb);
         chk("wdog_addr", wdog_addr, fb + 24'h000002);
         foreach (pa_list[k]) acc(pa_list[k], da_list[k], k == 5);
         repeat (40) begin
            rnd = lfsr(rnd);
            acc({8'h00, rnd[15:0]}, rnd[31] ? {16'hFFFF, rnd[7:0]} : {8'h00, rnd[23:8]}, rnd[29]);
         end
         for (int r = 0; r < 2; r++) begin
            for (int v = 0; v < 46; v++) vec(v[5:0]);
            mmdec_core_bfm_inst.cyc(1'b0, 24'h000000, 1'b0, 24'h000000, 1'b0, 1'b0, 6'h00);
            vector_base_wr = 1'b1;
            vector_base_wdata = 24'hFFFF80;
            @(posedge clk_sys);
            #1;
            vector_base_wr = 1'b0;
            base = 24'hFFFF80;
            chk("vector_base", vector_base, base);
         end
      end
      irq(45, 0, 45, 0, 6'h2D, 3'h1);
      irq(42, 0, 45, 0, 6'h2A, 3'h2);
      irq(40, 2, 42, 3, 6'h28, 3'h4);
      irq(2, 0, 42, 2, 6'h02, 3'h5);
      irq(44, 2, 42, 1, 6'h2C, 3'h4);
      clk_en = 1'b0;
      irq(45, 0, 45, 0, 6'h2C, 3'h4); // Frozen: the last winner stays
      chk("queues", pq.size() + dq.size() + vq.size(), 24'h000000);
      wrap_up();
   end
endmodule : mmdec_top_tb
